// ### core/hps_pattern_ram.sv
// Pattern memory with one write port and two registered read ports
`timescale 1ns/10ps
module hps_pattern_ram #(
    parameter int DEPTH = hps_pkg::MEM_DEPTH,
    parameter int WIDTH = hps_pkg::MEM_WIDTH,
    parameter int AW = hps_pkg::MEM_AW
) (
    // Clock and enable
    input wire logic clk_i,
    input wire logic ce_i,
    // Write port
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    // Read port a, register readback
    input wire logic rea_i,
    input wire logic [AW-1:0] raddra_i,
    output logic [WIDTH-1:0] rdataa_o,
    // Read port b, playback
    input wire logic reb_i,
    input wire logic [AW-1:0] raddrb_i,
    output logic [WIDTH-1:0] rdatab_o
);

    // Storage array, contents undefined until loaded
    logic [WIDTH-1:0] mem [DEPTH];

    // ------------------------------------------------------------------
    // Synchronous write and registered reads
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            if (we_i) begin
                mem[waddr_i] <= wdata_i;
            end
            if (rea_i) begin
                rdataa_o <= mem[raddra_i];
            end
            if (reb_i) begin
                rdatab_o <= mem[raddrb_i];
            end
        end
    end

endmodule

// ### core/hps_pkg.sv
// Shared constants, types and carriers of the haptic pattern sequencer
package hps_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_MEM_ADDR = 8'h28; // Pattern memory address
    localparam logic [7:0] REG_DATA_H = 8'h29; // Pattern word, high byte
    localparam logic [7:0] REG_DATA_M = 8'h2a; // Pattern word, middle byte
    localparam logic [7:0] REG_DATA_L = 8'h2b; // Pattern word, low byte
    localparam logic [7:0] REG_CTRL = 8'h31; // Direct control
    localparam logic [7:0] REG_START = 8'h33; // Pattern start address

    // ------------------------------------------------------------------
    // Direct control field positions
    // ------------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0; // driver_mode_select[4:0]
    localparam int CTRL_SW_TRIG = 5; // software_trigger_bit
    localparam int CTRL_MEM_EN = 6; // memory_access_enable
    localparam int CTRL_BUSY = 7; // Read-only playback status

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00; // All registers
    localparam logic [4:0] RST_MODE = 5'h00; // Driver off

    // ------------------------------------------------------------------
    // Driver mode codes, each naming its trigger source
    // ------------------------------------------------------------------
    localparam logic [4:0] MODE_EDGE_TRIGGERED_SEQUENCE_MODE_PIN0 = 5'h03;
    localparam logic [4:0] MODE_EDGE_TRIGGERED_SEQUENCE_MODE_PIN1 = 5'h04;
    localparam logic [4:0] MODE_RAM_PIN0 = 5'h05;
    localparam logic [4:0] MODE_RAM_PIN1 = 5'h06;

    // ------------------------------------------------------------------
    // Sample handling codes
    // ------------------------------------------------------------------
    localparam logic [1:0] CODE_LAST_PAT = 2'h0; // Last, repeat pattern
    localparam logic [1:0] CODE_NEXT = 2'h1; // Not last
    localparam logic [1:0] CODE_INTERP = 2'h2; // Interpolate to next; played here like CODE_NEXT, level not ramped
    localparam logic [1:0] CODE_LAST_SMP = 2'h3; // Last, repeat sample

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5; // 200 MHz core clock
    localparam int TIME_UNIT_NS = 5_000_000; // 5 ms step of all durations
    localparam int TICK_CYCLES = TIME_UNIT_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 20; // Holds TICK_CYCLES
    localparam int MEM_DEPTH = 256;
    localparam int MEM_WIDTH = 24;
    localparam int MEM_AW = 8;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        PH_IDLE = 4'b0000,
        PH_OD = 4'b0001,
        PH_ACT = 4'b0010,
        PH_ACT_EXT = 4'b0011,
        PH_BRK = 4'b0100,
        PH_FETCH = 4'b0101,
        PH_LOAD = 4'b0110,
        PH_DRIVE = 4'b0111,
        PH_WAIT = 4'b1000
    } hps_phase_e;

    // One stored sample, bit for bit as the three data bytes
    typedef struct packed {
        logic [1:0] code;
        logic sign;
        logic [6:0] amp;
        logic [4:0] dur;
        logic [4:0] wait_t;
        logic [3:0] rpt;
    } hps_sample_s;

    // Register access from the serial interface engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hps_reg_req_s;

    // Triggered sequence settings
    typedef struct packed {
        logic [7:0] od_level;
        logic [7:0] act_level;
        logic [7:0] brk_level;
        logic [7:0] od_time;
        logic [7:0] act_time;
        logic [7:0] brk_time;
    } hps_edge_triggered_sequence_mode_cfg_s;

endpackage

// ### core/hps_sequencer.sv
// Haptic sequencer: triggered three-phase and stored-pattern playback
//
// Behaviour
// - Start on trigger pin or software bit rise
// - Sequence runs overdrive, active, then brake
// - Level byte: bits 6:0 magnitude, bit 7 direction
// - Mode code selects which trigger input counts
// - Time each phase by its stored duration
// - Held trigger keeps active level until fall
// - Trigger fall on extended drive starts brake
// - Pattern memory is 256 words of 24 bits
// - Stored playback starts at start address
// - Address register picks word for data writes
// - Reading data registers returns word high-middle-low
// - High byte: code, sign, amplitude 6:2
// - Middle byte: amplitude 1:0, duration, wait 4
// - Low byte: wait 3:0, repetition count
// - Drive amplitude duration steps, then zero wait
// - Repetition count replays sample or pattern
// - Code 00 with count 0 is brake sample
`timescale 1ns/10ps
module hps_sequencer #(
    parameter int unsigned TICK_CYCLES = hps_pkg::TICK_CYCLES
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Register access
    input wire hps_pkg::hps_reg_req_s reg_req_i,
    output logic [7:0] reg_rdata_o,
    // Trigger pins, asynchronous
    input wire logic [1:0] trigger_pin_i,
    // Triggered sequence settings
    input wire hps_pkg::hps_edge_triggered_sequence_mode_cfg_s edge_triggered_sequence_mode_cfg_i,
    // Drive command
    output logic [6:0] drive_level_o,
    output logic drive_negative_o,
    output logic drive_active_o,
    output logic brake_active_o,
    output logic seq_busy_o
);

    localparam int TW = hps_pkg::TICK_W;

    // Whole state of the block
    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] pin_prev;
        logic sw_prev;
        logic [7:0] mem_addr;
        logic [7:0] data_h;
        logic [7:0] data_m;
        logic [7:0] data_l;
        logic [7:0] start_addr;
        logic [4:0] mode;
        logic sw_trig;
        logic mem_en;
        logic rb_pend;
        logic rb_take;
        logic [7:0] rdata;
        hps_pkg::hps_phase_e phase;
        logic [TW-1:0] presc;
        logic [7:0] units;
        logic [7:0] ptr;
        hps_pkg::hps_sample_s smp;
        logic [3:0] smp_rep;
        logic [3:0] pat_rep;
        logic pat_armed;
        logic [6:0] level;
        logic neg;
        logic drive;
        logic brake;
        logic busy; // Sequencer not idle, kept as a flop for the pin
    } hps_seq_state_s;

    hps_seq_state_s s; // Registered state
    hps_seq_state_s next_s; // Next state

    // Memory ports
    logic mem_we; // Commit of a full word
    logic [23:0] mem_rdata_a; // Readback word
    logic [23:0] mem_rdata_b; // Playback word

    // Decoded mode and trigger
    logic is_edge_triggered_sequence_mode; // Triggered three-phase mode
    logic is_ram; // Stored-pattern mode
    logic pin_sel; // Which pin the mode listens to
    logic trig_rise; // Start event
    logic trig_level; // Trigger still held
    logic tick; // One 5 ms step elapsed
    logic done; // Current timed phase over
    logic brake_smp; // Sample marks braking

    // ------------------------------------------------------------------
    // Mode and trigger decode
    // ------------------------------------------------------------------
    always_comb begin
        is_edge_triggered_sequence_mode = (s.mode == hps_pkg::MODE_EDGE_TRIGGERED_SEQUENCE_MODE_PIN0) ||
                  (s.mode == hps_pkg::MODE_EDGE_TRIGGERED_SEQUENCE_MODE_PIN1);
        is_ram = (s.mode == hps_pkg::MODE_RAM_PIN0) ||
                 (s.mode == hps_pkg::MODE_RAM_PIN1);
        // Pin choice follows the mode code
        pin_sel = (s.mode == hps_pkg::MODE_EDGE_TRIGGERED_SEQUENCE_MODE_PIN1) ||
                  (s.mode == hps_pkg::MODE_RAM_PIN1);
        // Edge needs the synchronised level, so short pulses vanish
        trig_rise = (s.sync2[pin_sel] && !s.pin_prev[pin_sel]) ||
                    (s.sw_trig && !s.sw_prev);
        trig_level = s.sync2[pin_sel] || s.sw_trig;
        tick = (s.presc == TW'(TICK_CYCLES - 1));
        // A zero duration ends the phase at once
        done = (s.units == 8'h00) || (tick && (s.units == 8'h01));
        brake_smp = (s.smp.code == hps_pkg::CODE_LAST_PAT) &&
                    (s.smp.rpt == 4'h0);
        // Word commits on the low byte, only while access is enabled
        mem_we = reg_req_i.wr && s.mem_en &&
                 (reg_req_i.addr == hps_pkg::REG_DATA_L);
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        // Two-stage synchroniser; edges look at the second stage only
        next_s.sync1 = trigger_pin_i;
        next_s.sync2 = s.sync1;
        next_s.pin_prev = s.sync2;
        next_s.sw_prev = s.sw_trig;
        next_s.rb_pend = 1'b0;
        next_s.rb_take = s.rb_pend;
        next_s.presc = tick ? '0 : s.presc + 1'b1;
        if (tick && s.units != 8'h00) begin
            next_s.units = s.units - 8'h01;
        end

        // Readback word lands in the data bytes two cycles after the
        // address write; a host byte write in that same cycle still wins,
        // so a word load right after an address write keeps its high byte.
        // Address itself stays put
        if (s.rb_take) begin
            next_s.data_h = mem_rdata_a[23:16];
            next_s.data_m = mem_rdata_a[15:8];
            next_s.data_l = mem_rdata_a[7:0];
        end

        // Register writes
        if (reg_req_i.wr) begin
            case (reg_req_i.addr)
                hps_pkg::REG_MEM_ADDR: begin
                    next_s.mem_addr = reg_req_i.wdata;
                    next_s.rb_pend = 1'b1;
                end
                hps_pkg::REG_DATA_H: next_s.data_h = reg_req_i.wdata;
                hps_pkg::REG_DATA_M: next_s.data_m = reg_req_i.wdata;
                hps_pkg::REG_DATA_L: next_s.data_l = reg_req_i.wdata;
                hps_pkg::REG_CTRL: begin
                    next_s.mode = reg_req_i.wdata[hps_pkg::CTRL_MODE_LSB +: 5];
                    next_s.sw_trig = reg_req_i.wdata[hps_pkg::CTRL_SW_TRIG];
                    next_s.mem_en = reg_req_i.wdata[hps_pkg::CTRL_MEM_EN];
                end
                hps_pkg::REG_START: next_s.start_addr = reg_req_i.wdata;
                default: begin
                    // Other offsets belong to other blocks
                end
            endcase
        end
        // Register reads, answered one cycle later
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                hps_pkg::REG_MEM_ADDR: next_s.rdata = s.mem_addr;
                hps_pkg::REG_DATA_H: next_s.rdata = s.data_h;
                hps_pkg::REG_DATA_M: next_s.rdata = s.data_m;
                hps_pkg::REG_DATA_L: next_s.rdata = s.data_l;
                hps_pkg::REG_CTRL: next_s.rdata = {s.phase != hps_pkg::PH_IDLE,
                    s.mem_en, s.sw_trig, s.mode};
                hps_pkg::REG_START: next_s.rdata = s.start_addr;
                default: next_s.rdata = 8'h00;
            endcase
        end

        // Sequencer; entering a timed phase restarts its step clock
        case (s.phase)
            hps_pkg::PH_IDLE: begin
                if (trig_rise && is_edge_triggered_sequence_mode) begin
                    next_s.phase = hps_pkg::PH_OD;
                    next_s.units = edge_triggered_sequence_mode_cfg_i.od_time;
                    next_s.presc = '0;
                end else if (trig_rise && is_ram) begin
                    next_s.phase = hps_pkg::PH_FETCH;
                    next_s.ptr = s.start_addr;
                    next_s.pat_armed = 1'b0;
                end
            end
            hps_pkg::PH_OD: begin
                if (done) begin
                    next_s.phase = hps_pkg::PH_ACT;
                    next_s.units = edge_triggered_sequence_mode_cfg_i.act_time;
                    next_s.presc = '0;
                end
            end
            hps_pkg::PH_ACT: begin
                if (done) begin
                    next_s.phase = trig_level ? hps_pkg::PH_ACT_EXT
                                              : hps_pkg::PH_BRK;
                    next_s.units = edge_triggered_sequence_mode_cfg_i.brk_time;
                    next_s.presc = '0;
                end
            end
            hps_pkg::PH_ACT_EXT: begin
                if (!trig_level) begin
                    next_s.phase = hps_pkg::PH_BRK;
                    next_s.units = edge_triggered_sequence_mode_cfg_i.brk_time;
                    next_s.presc = '0;
                end
            end
            hps_pkg::PH_BRK: begin
                if (done) begin
                    next_s.phase = hps_pkg::PH_IDLE;
                end
            end
            hps_pkg::PH_FETCH: next_s.phase = hps_pkg::PH_LOAD;
            hps_pkg::PH_LOAD: begin
                // Fields fall out of the word by position
                next_s.smp = hps_pkg::hps_sample_s'(mem_rdata_b);
                next_s.smp_rep = mem_rdata_b[3:0];
                next_s.phase = hps_pkg::PH_DRIVE;
                next_s.units = {3'h0, mem_rdata_b[13:9]};
                next_s.presc = '0;
            end
            hps_pkg::PH_DRIVE: begin
                if (done) begin
                    next_s.phase = hps_pkg::PH_WAIT;
                    next_s.units = {3'h0, s.smp.wait_t};
                    next_s.presc = '0;
                end
            end
            hps_pkg::PH_WAIT: begin
                if (done) begin
                    next_s.units = {3'h0, s.smp.dur};
                    next_s.presc = '0;
                    if (s.smp.code != hps_pkg::CODE_LAST_PAT &&
                        s.smp_rep != 4'h0) begin
                        // Replay this sample without refetching
                        next_s.smp_rep = s.smp_rep - 4'h1;
                        next_s.phase = hps_pkg::PH_DRIVE;
                    end else if (s.smp.code == hps_pkg::CODE_NEXT ||
                                 s.smp.code == hps_pkg::CODE_INTERP) begin
                        next_s.ptr = s.ptr + 8'h01;
                        next_s.phase = hps_pkg::PH_FETCH;
                    end else if (s.smp.code == hps_pkg::CODE_LAST_SMP) begin
                        next_s.phase = hps_pkg::PH_IDLE;
                    end else if ((s.pat_armed ? s.pat_rep : s.smp.rpt)
                                 != 4'h0) begin
                        // Whole pattern again from the start
                        next_s.pat_rep = (s.pat_armed ? s.pat_rep
                                                      : s.smp.rpt) - 4'h1;
                        next_s.pat_armed = 1'b1;
                        next_s.ptr = s.start_addr;
                        next_s.phase = hps_pkg::PH_FETCH;
                    end else begin
                        next_s.phase = hps_pkg::PH_IDLE;
                    end
                end
            end
            default: next_s.phase = hps_pkg::PH_IDLE;
        endcase

        // Leaving both sequence modes aborts whatever runs
        if (!is_edge_triggered_sequence_mode && !is_ram) begin
            next_s.phase = hps_pkg::PH_IDLE;
        end

        // Drive command follows the phase being entered
        next_s.level = 7'h00;
        next_s.neg = 1'b0;
        next_s.drive = 1'b1;
        next_s.brake = 1'b0;
        next_s.busy = (next_s.phase != hps_pkg::PH_IDLE);
        case (next_s.phase)
            hps_pkg::PH_OD: {next_s.neg, next_s.level} = edge_triggered_sequence_mode_cfg_i.od_level;
            hps_pkg::PH_ACT, hps_pkg::PH_ACT_EXT:
                {next_s.neg, next_s.level} = edge_triggered_sequence_mode_cfg_i.act_level;
            hps_pkg::PH_BRK: begin
                {next_s.neg, next_s.level} = edge_triggered_sequence_mode_cfg_i.brk_level;
                next_s.brake = 1'b1;
            end
            hps_pkg::PH_DRIVE: begin
                next_s.level = next_s.smp.amp;
                next_s.neg = next_s.smp.sign;
                next_s.brake = (next_s.smp.code == hps_pkg::CODE_LAST_PAT) &&
                               (next_s.smp.rpt == 4'h0);
            end
            hps_pkg::PH_WAIT: next_s.brake = brake_smp;
            default: next_s.drive = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // State register; enable low freezes everything
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    // Pattern memory, 256 by 24
    hps_pattern_ram u_ram (
        .clk_i(clk_i),
        .ce_i(ce_i),
        .we_i(mem_we),
        .waddr_i(s.mem_addr),
        .wdata_i({s.data_h, s.data_m, reg_req_i.wdata}),
        .rea_i(s.rb_pend),
        .raddra_i(s.mem_addr),
        .rdataa_o(mem_rdata_a),
        .reb_i(s.phase == hps_pkg::PH_FETCH),
        .raddrb_i(s.ptr),
        .rdatab_o(mem_rdata_b)
    );

    assign reg_rdata_o = s.rdata;
    assign drive_level_o = s.level;
    assign drive_negative_o = s.neg;
    assign drive_active_o = s.drive;
    assign brake_active_o = s.brake;
    assign seq_busy_o = s.busy;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_idle_start;
        ce_i && s.phase == hps_pkg::PH_IDLE && trig_rise && !reg_req_i.wr;
    endsequence

    sequence s_ext_release;
        ce_i && is_edge_triggered_sequence_mode && s.phase == hps_pkg::PH_ACT_EXT && !trig_level;
    endsequence

    a_edge_triggered_sequence_mode_start: assert property (
        s_idle_start and is_edge_triggered_sequence_mode |=> s.phase == hps_pkg::PH_OD)
        else $error("triggered sequence did not start");
    a_od_level: assert property (
        s.phase == hps_pkg::PH_OD |->
        {drive_negative_o, drive_level_o} == edge_triggered_sequence_mode_cfg_i.od_level)
        else $error("overdrive level mismatch");
    a_phase_order: assert property (
        $fell(s.phase == hps_pkg::PH_OD) && s.phase != hps_pkg::PH_IDLE
        |-> s.phase == hps_pkg::PH_ACT)
        else $error("active did not follow overdrive");
    a_extend_hold: assert property (
        ce_i && is_edge_triggered_sequence_mode && s.phase == hps_pkg::PH_ACT_EXT && trig_level
        |=> s.phase == hps_pkg::PH_ACT_EXT && drive_level_o ==
            edge_triggered_sequence_mode_cfg_i.act_level[6:0])
        else $error("extended active drive lost");
    a_fall_brake: assert property (
        s_ext_release |=> s.phase == hps_pkg::PH_BRK && brake_active_o)
        else $error("brake not entered on trigger fall");
    a_ram_start: assert property (
        s_idle_start and is_ram |=> s.ptr == $past(s.start_addr)
        ##1 s.phase == hps_pkg::PH_LOAD || !$past(ce_i))
        else $error("playback did not start at start address");
    a_wait_zero: assert property (
        s.phase == hps_pkg::PH_WAIT |-> drive_level_o == 7'h00)
        else $error("nonzero level during wait");
    a_addr_stable: assert property (
        ce_i && !(reg_req_i.wr && reg_req_i.addr == hps_pkg::REG_MEM_ADDR)
        |=> $stable(s.mem_addr))
        else $error("memory address moved by itself");
    a_readback: assert property (
        ce_i && reg_req_i.wr && reg_req_i.addr == hps_pkg::REG_MEM_ADDR
        |=> s.rb_pend)
        else $error("readback not requested after address write");

endmodule

// ### verif/haptic_pattern_sequencer_tb.sv
// Self-checking bench of the haptic sequencer
`timescale 1ns/10ps
module haptic_pattern_sequencer_tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    hps_pkg::hps_reg_req_s req;
    logic [1:0] trig;
    logic [7:0] rdata;
    logic [7:0] v;
    logic [6:0] lvl;
    logic neg, drv, brk, busy;
    logic ce = 1'b1; // Clock enable, dropped in one test
    int miscompares = 0;
    int n_checks = 0;
    // Rows: memory address above the stored word
    logic [31:0] rows [4] = '{32'h05ea8210, 32'h00ffffff,
                              32'hff000001, 32'h805a3c96};
    // Short time step keeps each phase to four cycles
    hps_pkg::hps_edge_triggered_sequence_mode_cfg_s cfg = '{8'h91, 8'h22, 8'h33,
                                    8'h01, 8'h01, 8'h01};
    initial forever #2.5 clk_i = ~clk_i;
    hps_sequencer #(.TICK_CYCLES(4)) u_dut (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .ce_i(ce), .reg_req_i(req),
        .reg_rdata_o(rdata), .trigger_pin_i(trig), .edge_triggered_sequence_mode_cfg_i(cfg),
        .drive_level_o(lvl), .drive_negative_o(neg),
        .drive_active_o(drv), .brake_active_o(brk), .seq_busy_o(busy));
    hps_host_model u_host (.clk_i(clk_i), .req_o(req), .trig_o(trig),
        .rdata_i(rdata));
    // Compare and count
    task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bounded wait for the drive level to move away from a value
    task automatic wait_lvl(input logic [6:0] old);
        for (int i = 0; i < 200 && lvl === old; i++) @(negedge clk_i);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Watchdog well beyond the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (12) @(negedge clk_i);
        chk("reset outputs", 24'h0, {lvl, neg, drv, brk, busy});
        rst_n_i = 1'b1;
        // ----------------------------------------------------------
        // Memory rows: write all, then read each back
        // ----------------------------------------------------------
        u_host.wr(hps_pkg::REG_CTRL, 8'h40);
        foreach (rows[i]) begin
            u_host.wr(hps_pkg::REG_MEM_ADDR, rows[i][31:24]);
            u_host.wr(hps_pkg::REG_DATA_H, rows[i][23:16]);
            u_host.wr(hps_pkg::REG_DATA_M, rows[i][15:8]);
            u_host.wr(hps_pkg::REG_DATA_L, rows[i][7:0]);
        end
        foreach (rows[i]) begin
            u_host.wr(hps_pkg::REG_MEM_ADDR, rows[i][31:24]);
            repeat (3) @(negedge clk_i);
            u_host.rd(hps_pkg::REG_DATA_H, v);
            chk("data high", rows[i][23:16], v);
            u_host.rd(hps_pkg::REG_DATA_M, v);
            chk("data middle", rows[i][15:8], v);
            u_host.rd(hps_pkg::REG_DATA_L, v);
            chk("data low", rows[i][7:0], v);
            u_host.rd(hps_pkg::REG_MEM_ADDR, v);
            chk("address kept", rows[i][31:24], v);
        end
        u_host.rd(8'h30, v);
        chk("unmapped read", 24'h0, v);
        $display("memory rows done");
        // Software trigger, active held by the bit, then brake
        u_host.wr(hps_pkg::REG_CTRL, 8'h03);
        u_host.wr(hps_pkg::REG_CTRL, 8'h23);
        wait_lvl(7'h00);
        chk("overdrive", {cfg.od_level, 1'b1}, {neg, lvl, drv});
        wait_lvl(7'h11);
        chk("active", 24'h22, lvl);
        repeat (30) @(negedge clk_i);
        chk("extended active", 24'h22, lvl);
        u_host.wr(hps_pkg::REG_CTRL, 8'h03);
        wait_lvl(7'h22);
        chk("brake", 24'h67, {lvl, brk});
        wait_lvl(7'h33);
        repeat (3) @(negedge clk_i);
        chk("idle after brake", 24'h0, busy);
        $display("software trigger done");
        // Pin 1 selected: pin 0 ignored, pin 1 held past active time
        u_host.wr(hps_pkg::REG_CTRL, 8'h04);
        u_host.hold(0, 8);
        repeat (4) @(negedge clk_i);
        chk("unselected pin", 24'h0, busy);
        fork
            u_host.hold(1, 60);
            begin
                wait_lvl(7'h00);
                chk("pin overdrive", cfg.od_level, {neg, lvl});
                wait_lvl(7'h11);
                wait_lvl(7'h22);
                chk("left after fall", 24'h0, trig);
                chk("pin brake", 24'h67, {lvl, brk});
            end
        join
        $display("pin trigger done");
        // Stored pattern from start address, last sample code 11
        u_host.wr(hps_pkg::REG_START, 8'h05);
        u_host.wr(hps_pkg::REG_CTRL, 8'h45);
        repeat (20) @(negedge clk_i);
        u_host.wr(hps_pkg::REG_CTRL, 8'h65);
        wait_lvl(7'h00);
        chk("sample level", 24'h55, {lvl, neg});
        wait_lvl(7'h2a);
        repeat (8) @(negedge clk_i);
        chk("pattern stop", 24'h0, {busy, lvl});
        $display("stored pattern done");
        // Pin 1 pattern from the last word: code 00, one pattern repeat
        u_host.wr(hps_pkg::REG_START, 8'hff);
        u_host.wr(hps_pkg::REG_CTRL, 8'h06);
        u_host.hold(1, 4);
        repeat (4) @(negedge clk_i);
        chk("pattern repeat", 24'h1, busy);
        repeat (8) @(negedge clk_i);
        chk("repeat end", 24'h0, busy);
        $display("pattern repeat done");
        // Enable low freezes the overdrive phase past its time
        u_host.wr(hps_pkg::REG_CTRL, 8'h03);
        u_host.wr(hps_pkg::REG_CTRL, 8'h23);
        @(negedge clk_i);
        ce = 1'b0;
        repeat (20) @(negedge clk_i);
        chk("frozen overdrive", {cfg.od_level, 1'b1}, {neg, lvl, drv});
        ce = 1'b1;
        // Reset in mid-sequence clears every output at once
        rst_n_i = 1'b0;
        @(negedge clk_i);
        chk("mid-run reset", 24'h0, {lvl, neg, drv, brk, busy});
        rst_n_i = 1'b1;
        $display("enable and reset done");
        wrap_up();
    end
endmodule

// ### verif/hps_host_model.sv
// Host model: register requests and trigger pins toward the sequencer
`timescale 1ns/10ps
module hps_host_model (
    // Clock
    input wire logic clk_i,
    // Requests and pins driven toward the sequencer
    output hps_pkg::hps_reg_req_s req_o,
    output logic [1:0] trig_o,
    // Read data back from the sequencer
    input wire logic [7:0] rdata_i
);
    // Idle bus and low pins from time zero
    initial begin
        req_o = '0;
        trig_o = 2'h0;
    end
    // One-cycle write, changed only at falling edges
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        req_o = '{1'b1, 1'b0, a, d};
        @(negedge clk_i);
        req_o = '0;
    endtask
    // Read; data settles in the cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        req_o = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk_i);
        req_o = '0;
        d = rdata_i;
    endtask
    // Pin pulse held long enough for the two-flop sync to see it
    task automatic hold(input int p, input int n);
        trig_o[p] = 1'b1;
        repeat (n) @(negedge clk_i);
        trig_o[p] = 1'b0;
    endtask
endmodule
